// *** hdl/uart_status_pkg.sv ***
// Constants, register map and carrier types for the UART status and baud register slice
package uart_status_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [4:0] OFS_DIV_LOW = 5'h00;
	localparam logic [4:0] OFS_DIV_HIGH = 5'h01;
	localparam logic [4:0] OFS_OVERSAMPLE = 5'h02;
	localparam logic [4:0] OFS_LINE_CTRL = 5'h04;
	localparam logic [4:0] OFS_LINE_STATE = 5'h05;
	localparam logic [4:0] OFS_HANDSHAKE = 5'h06;
	localparam logic [4:0] OFS_FEATURE = 5'h07;
	localparam logic [4:0] OFS_RX_COUNT = 5'h15;
	localparam logic [4:0] OFS_TX_COUNT = 5'h16;
	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int LINE_CTRL_BANK_BIT = 7;
	localparam int FEAT_FORCE_TX_BIT = 0;
	localparam int FEAT_DSR_DTR_BIT = 1;
	localparam int FEAT_MODE950_BIT = 5;
	localparam int FEAT_RXSEL_BIT = 6;
	localparam int FEAT_TXSEL_BIT = 7;
	localparam logic [7:0] FEAT_WRITE_MASK = 8'hf3; // Bits 3:2 read-only zero
	localparam logic [7:0] OVS_WRITE_MASK = 8'h0f; // Bits 7:4 reserved
	////////////////////////////////////////////////////////////////////////////
	// Reset values and sample counts
	localparam logic [7:0] LINE_CTRL_RESET = 8'h03;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [4:0] SAMPLES_AT_CODE0 = 5'h10;
	////////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef struct packed {
		logic rx_has_data;   // Receive FIFO not empty
		logic rx_overrun;    // Overrun seen
		logic rx_parity_err; // Parity error
		logic rx_frame_err;  // Framing error
		logic rx_break;      // Break detected
		logic tx_hold_empty; // Holding register empty
		logic tx_shift_empty; // Shift register empty
		logic rx_fifo_err;   // Error in FIFO data
	} line_events_type;
	typedef struct packed {
		logic dcd; // Carrier detect
		logic ri;  // Ring indicator
		logic dsr; // Data set ready
		logic cts; // Clear to send
	} modem_lines_type;
	typedef struct packed {
		logic [15:0] divisor;        // Baud divisor
		logic [4:0] samples_per_bit; // Samples per bit
		logic force_tx;              // Force transmission
		logic dsr_dtr_flow;          // DSR/DTR flow control
		logic mode_950;              // 950 mode
		logic divisor_bank;          // Divisor latch selected
	} baud_config_type;
endpackage

// *** hdl/modem_change_detect.sv ***
// Modem line level capture and change-detect flags with read clear
`timescale 1ns/1ps
`default_nettype none
module modem_change_detect
	import uart_status_pkg::*;
(
	input wire logic core_clk,           // Core clock
	input wire logic arst_n,             // Async reset, active low
	input wire modem_lines_type lines,   // Modem input levels
	input wire logic read_clear,         // Status register read
	output logic [7:0] status_q          // Status byte
);
	modem_lines_type prev_q; // Last sampled levels
	logic [3:0] delta;       // Qualifying changes this cycle
	wire logic [3:0] flag_d; // Next change flags
	always_comb begin
		delta[0] = lines.cts ^ prev_q.cts;
		delta[1] = lines.dsr ^ prev_q.dsr;
		delta[2] = lines.ri & ~prev_q.ri;
		delta[3] = lines.dcd ^ prev_q.dcd;
	end
	////////////////////////////////////////////////////////////////////////////
	// Level history; reset to zero so a high input after reset counts as change
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_q <= '0;
		end else begin
			prev_q <= lines;
		end
	end
	// Sticky flags: new change beats the read clear
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_flag
			assign flag_d[i] = delta[i] | (status_q[i] & ~read_clear);
		end
	endgenerate
	// Flags and present levels in one register, so every bit has a single driver
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_q <= 8'h00;
		end else begin
			status_q <= {lines.dcd, lines.ri, lines.dsr, lines.cts, flag_d};
		end
	end
endmodule
`default_nettype wire

// *** hdl/sample_count_decode.sv ***
// Decode of the oversample code into samples per bit
`timescale 1ns/1ps
`default_nettype none
module sample_count_decode
	import uart_status_pkg::*;
(
	input wire logic [3:0] code,          // Oversample code
	output logic [4:0] samples_per_bit    // Samples per bit
);
	// Descending pattern, extended past the listed codes
	always_comb begin
		samples_per_bit = SAMPLES_AT_CODE0 - {1'b0, code};
	end
endmodule
`default_nettype wire

// *** hdl/uart_status_regs.sv ***
// Line status, modem status, feature control and divisor registers of one channel
`timescale 1ns/1ps
`default_nettype none
module uart_status_regs
	import uart_status_pkg::*;
(
	input wire logic core_clk,                 // Core clock
	input wire logic arst_n,                   // Async reset, active low
	input wire logic [4:0] reg_addr,           // Register offset
	input wire logic reg_wr,                   // Write strobe, one cycle
	input wire logic reg_rd,                   // Read strobe, one cycle
	input wire logic [7:0] reg_wdata,          // Write data
	output logic [7:0] reg_rdata_q,            // Read data, one cycle after strobe
	input wire line_events_type line_events,   // Receiver and transmitter state
	input wire modem_lines_type modem_lines,   // Modem input levels
	input wire logic [7:0] rx_fill_count,      // Receive FIFO fill level
	input wire logic [7:0] line_err_count,     // Line status counter
	input wire logic [7:0] tx_fill_count,      // Transmit FIFO fill level
	output baud_config_type baud_config_q      // Configuration to datapath
);
	////////////////////////////////////////////////////////////////////////////
	// Storage
	logic [7:0] line_ctrl_q;   // Line format control
	logic [7:0] feature_q;     // Extra feature control
	logic [7:0] div_low_q;     // Divisor low
	logic [7:0] div_high_q;    // Divisor high
	logic [7:0] ovs_q;         // Oversample code
	logic [7:0] line_state_q;  // Captured line status
	logic [7:0] hs_status;     // Modem status byte
	logic [4:0] samples;       // Decoded sample count
	logic bank_div;            // Divisor bank selected
	logic hs_read;             // Modem status read
	assign bank_div = line_ctrl_q[LINE_CTRL_BANK_BIT];
	assign hs_read = reg_rd && (reg_addr == OFS_HANDSHAKE);
	////////////////////////////////////////////////////////////////////////////
	// Submodules
	modem_change_detect u_modem (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.lines(modem_lines),
		.read_clear(hs_read),
		.status_q(hs_status)
	);
	sample_count_decode u_decode (
		.code(ovs_q[3:0]),
		.samples_per_bit(samples)
	);
	////////////////////////////////////////////////////////////////////////////
	// Line status capture: status bits mirror datapath state, registered
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			line_state_q <= REG_RESET; // Bit 5 included, reset value is zero
		end else begin
			line_state_q[0] <= line_events.rx_has_data;
			line_state_q[1] <= line_events.rx_overrun;
			line_state_q[2] <= line_events.rx_parity_err;
			line_state_q[3] <= line_events.rx_frame_err;
			line_state_q[4] <= line_events.rx_break;
			line_state_q[5] <= line_events.tx_hold_empty;
			line_state_q[6] <= line_events.tx_shift_empty;
			line_state_q[7] <= line_events.rx_fifo_err;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Line control; only bank select is used here, rest stored for readback
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			line_ctrl_q <= LINE_CTRL_RESET;
		end else if (reg_wr && reg_addr == OFS_LINE_CTRL) begin
			line_ctrl_q <= reg_wdata;
		end
	end
	// Feature control; reserved bits 3:2 stay zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			feature_q <= REG_RESET;
		end else if (reg_wr && reg_addr == OFS_FEATURE) begin
			feature_q <= reg_wdata & FEAT_WRITE_MASK;
		end
	end
	// Divisor latch pair, reachable only with the bank bit set
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_low_q <= REG_RESET;
			div_high_q <= REG_RESET;
		end else if (reg_wr && bank_div) begin
			if (reg_addr == OFS_DIV_LOW) begin
				div_low_q <= reg_wdata;
			end
			if (reg_addr == OFS_DIV_HIGH) begin
				div_high_q <= reg_wdata;
			end
		end
	end
	// Oversample code: at 02h in divisor bank, or at 16h when feature bit 7 is 0
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ovs_q <= REG_RESET;
		end else if (reg_wr && ((bank_div && reg_addr == OFS_OVERSAMPLE)
				|| (!feature_q[FEAT_TXSEL_BIT] && reg_addr == OFS_TX_COUNT))) begin
			ovs_q <= reg_wdata & OVS_WRITE_MASK;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Configuration out, registered
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			baud_config_q <= '0;
		end else begin
			baud_config_q.divisor <= {div_high_q, div_low_q};
			baud_config_q.samples_per_bit <= samples;
			baud_config_q.force_tx <= feature_q[FEAT_FORCE_TX_BIT];
			baud_config_q.dsr_dtr_flow <= feature_q[FEAT_DSR_DTR_BIT];
			baud_config_q.mode_950 <= feature_q[FEAT_MODE950_BIT];
			baud_config_q.divisor_bank <= bank_div;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped or bank-hidden offsets read zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= REG_RESET;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_DIV_LOW: reg_rdata_q <= bank_div ? div_low_q : REG_RESET;
				OFS_DIV_HIGH: reg_rdata_q <= bank_div ? div_high_q : REG_RESET;
				OFS_OVERSAMPLE: reg_rdata_q <= bank_div ? ovs_q : REG_RESET;
				OFS_LINE_CTRL: reg_rdata_q <= line_ctrl_q;
				OFS_LINE_STATE: reg_rdata_q <= line_state_q;
				OFS_HANDSHAKE: reg_rdata_q <= hs_status; // Clears change bits
				OFS_FEATURE: reg_rdata_q <= feature_q;
				OFS_RX_COUNT: begin
					// Error counter or fill level
					reg_rdata_q <= feature_q[FEAT_RXSEL_BIT] ? line_err_count : rx_fill_count;
				end
				OFS_TX_COUNT: begin
					// Fill level or oversample code
					reg_rdata_q <= feature_q[FEAT_TXSEL_BIT] ? tx_fill_count : ovs_q;
				end
				default: reg_rdata_q <= REG_RESET;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** verification/uart_status_regs_assertions.sv ***
// Assertion checker for the status and baud register slice
`timescale 1ns/1ps
`default_nettype none
module uart_status_regs_assertions
	import uart_status_pkg::*;
(
	input wire logic core_clk, // Clock
	input wire logic arst_n, // Reset
	input wire logic [4:0] reg_addr, // Offset
	input wire logic reg_wr, // Write
	input wire logic reg_rd, // Read
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata_q, // Read data
	input wire line_events_type line_events, // Line state
	input wire modem_lines_type modem_lines, // Modem levels
	input wire baud_config_type baud_config_q // Config
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Line status byte runs bit 0 upward from the struct's top member
	wire logic [7:0] line_state_exp = {line_events.rx_fifo_err, line_events.tx_shift_empty, line_events.tx_hold_empty,
		line_events.rx_break, line_events.rx_frame_err, line_events.rx_parity_err, line_events.rx_overrun,
		line_events.rx_has_data};
	wire logic rd6 = reg_rd && reg_addr == OFS_HANDSHAKE; // Modem status read
	wire logic bank = baud_config_q.divisor_bank; // Divisor bank
	property p_line_state;
		reg_rd && reg_addr == OFS_LINE_STATE && $past(arst_n) && $stable(line_events)
			|=> reg_rdata_q == $past(line_state_exp, 2);
	endproperty
	a_line_state: assert property (p_line_state) else $error("line status");
	property p_lvl;
		rd6 && $past(arst_n) |=> reg_rdata_q[7:4] == $past(modem_lines, 2);
	endproperty
	a_lvl: assert property (p_lvl) else $error("modem levels");
	property p_cts;
		$changed(modem_lines.cts) && $past(arst_n) ##1 rd6 |=> reg_rdata_q[0];
	endproperty
	a_cts: assert property (p_cts) else $error("cts change");
	property p_ri;
		$rose(modem_lines.ri) && $past(arst_n) ##1 rd6 |=> reg_rdata_q[2];
	endproperty
	a_ri: assert property (p_ri) else $error("ri rise");
	// Quiet lines between two reads leave nothing to report
	property p_clr;
		rd6 && $past(arst_n) && $stable(modem_lines) ##1 $stable(modem_lines) ##1 rd6 && $stable(modem_lines)
			|=> reg_rdata_q[3:0] == 4'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("change not cleared");
	property p_dlo;
		reg_wr && reg_addr == OFS_DIV_LOW && bank && !$past(reg_wr) ##1 !reg_wr
			|=> baud_config_q.divisor[7:0] == $past(reg_wdata, 2);
	endproperty
	a_dlo: assert property (p_dlo) else $error("divisor low");
	property p_spb;
		reg_wr && reg_addr == OFS_OVERSAMPLE && bank && !$past(reg_wr) ##1 !reg_wr
			|=> baud_config_q.samples_per_bit == SAMPLES_AT_CODE0 - {1'b0, $past(reg_wdata[3:0], 2)};
	endproperty
	a_spb: assert property (p_spb) else $error("samples per bit");
	property p_feat;
		reg_wr && reg_addr == OFS_FEATURE ##1 !reg_wr |=> {baud_config_q.force_tx, baud_config_q.dsr_dtr_flow,
			baud_config_q.mode_950} == {$past(reg_wdata[0], 2), $past(reg_wdata[1], 2), $past(reg_wdata[5], 2)};
	endproperty
	a_feat: assert property (p_feat) else $error("feature bits");
	property p_gate;
		reg_rd && reg_addr == OFS_DIV_LOW && !bank && !$past(reg_wr) |=> reg_rdata_q == 8'h00;
	endproperty
	a_gate: assert property (p_gate) else $error("bank gate");
endmodule
bind uart_status_regs uart_status_regs_assertions u_chk(.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .line_events(line_events),
	.modem_lines(modem_lines), .baud_config_q(baud_config_q));
`default_nettype wire

// *** verification/modem_peer.sv ***
// Remote modem peer driving the handshake lines
`timescale 1ns/1ps
`default_nettype none
module modem_peer
	import uart_status_pkg::*;
(
	input wire logic core_clk, // Clock
	output var modem_lines_type lines // Levels
);
	initial lines = '0;
	// Move only after a falling edge, clear of sampling
	task automatic set(input modem_lines_type v);
		@(negedge core_clk);
		lines = v;
	endtask
endmodule
`default_nettype wire

// *** verification/tb_uart_status_regs.sv ***
// Self-checking bench for the status and baud register slice
`timescale 1ns/1ps
`default_nettype none
module tb_uart_status_regs
	import uart_status_pkg::*;
;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata_q;
	line_events_type line_events = '0;
	logic [7:0] rx_fill = 8'h11; // Receive fill level seen by the block
	logic [7:0] err_tally = 8'h22; // Line status counter seen by the block
	logic [7:0] tx_fill = 8'h33; // Transmit fill level seen by the block
	modem_lines_type modem_lines;
	baud_config_type baud_config_q;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	initial forever #4 core_clk = ~core_clk;
	modem_peer u_peer(.core_clk(core_clk), .lines(modem_lines));
	uart_status_regs u_dut(.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .line_events(line_events), .modem_lines(modem_lines),
		.rx_fill_count(rx_fill), .line_err_count(err_tally), .tx_fill_count(tx_fill), .baud_config_q(baud_config_q));
	task automatic chk(input logic [24:0] got, input logic [24:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	// Read data is settled by the next falling edge
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk({17'h0, reg_rdata_q}, {17'h0, exp});
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(OFS_LINE_STATE, 8'h00);
		rd(OFS_FEATURE, 8'h00);
		chk(baud_config_q, {16'h0000, 5'h10, 4'h0});
	endtask
	// Walk a single flag across the line status byte
	task automatic t_lsr();
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			line_events = line_events_type'(8'h80 >> i);
			rd(OFS_LINE_STATE, 8'h01 << i);
		end
	endtask
	task automatic t_modem();
		rd(OFS_HANDSHAKE, 8'h00);
		u_peer.set(4'hf);
		rd(OFS_HANDSHAKE, 8'hff);
		rd(OFS_HANDSHAKE, 8'hf0);
		u_peer.set(4'h0);
		rd(OFS_HANDSHAKE, 8'h0b);
		rd(OFS_HANDSHAKE, 8'h00);
		// Change landing on the read edge must survive that read
		fork
			u_peer.set(4'h1);
			rd(OFS_HANDSHAKE, 8'h00);
		join
		rd(OFS_HANDSHAKE, 8'h11);
	endtask
	task automatic t_div();
		wr(OFS_DIV_LOW, 8'h5a);
		rd(OFS_DIV_LOW, 8'h00);
		wr(OFS_LINE_CTRL, 8'h83);
		rd(OFS_LINE_CTRL, 8'h83);
		chk(baud_config_q.divisor_bank, 1'b1);
		wr(OFS_DIV_LOW, 8'h5a);
		wr(OFS_DIV_HIGH, 8'ha5);
		rd(OFS_DIV_LOW, 8'h5a);
		rd(OFS_DIV_HIGH, 8'ha5);
		chk(baud_config_q.divisor, 16'ha55a);
		// Every code, reserved upper bits written high
		for (int c = 0; c < 16; c++) begin
			wr(OFS_OVERSAMPLE, {4'hf, c[3:0]});
			rd(OFS_OVERSAMPLE, {4'h0, c[3:0]});
			chk(baud_config_q.samples_per_bit, 5'h10 - c[4:0]);
		end
		wr(OFS_LINE_CTRL, 8'h03);
		rd(OFS_DIV_HIGH, 8'h00);
	endtask
	task automatic t_feat();
		wr(OFS_FEATURE, 8'hff);
		rd(OFS_FEATURE, 8'hf3);
		chk({baud_config_q.force_tx, baud_config_q.dsr_dtr_flow, baud_config_q.mode_950}, 3'h7);
		rd(OFS_RX_COUNT, 8'h22);
		rd(OFS_TX_COUNT, 8'h33);
		wr(OFS_FEATURE, 8'h00);
		rx_fill = 8'h44;
		rd(OFS_RX_COUNT, 8'h44);
		chk({baud_config_q.force_tx, baud_config_q.dsr_dtr_flow, baud_config_q.mode_950}, 3'h0);
		// Offset 16h now aliases the oversample code left by the divisor test
		rd(OFS_TX_COUNT, 8'h0f);
		wr(OFS_TX_COUNT, 8'h02);
		rd(OFS_TX_COUNT, 8'h02);
		chk(baud_config_q.samples_per_bit, 5'h0e);
		rd(5'h1f, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Hang guard, far above the roughly 150 cycles needed
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(negedge core_clk);
		arst_n = 1'b1;
		t_reset();
		t_lsr();
		t_modem();
		t_div();
		t_feat();
		summarize();
	end
endmodule
`default_nettype wire
